// file: logic/cbm_exec.sv
`timescale 1ns/1ps
// Functional notes
// - Signed greater-or-equal branch jumps to PC+offset+1 when negative XOR overflow is 0.
// - Signed less-than branch jumps to PC+offset+1 when negative XOR overflow is 1.
// - Half-carry-set branch jumps to PC+offset+1 only when half-carry is 1.
// - Half-carry-clear branch jumps to PC+offset+1 only when half-carry is 0.
// - Transfer-bit-set branch jumps to PC+offset+1 when the T flag is 1.
// - Transfer-bit-clear branch jumps to PC+offset+1 when the T flag is 0.
// - Overflow-set branch jumps to PC+offset+1 when overflow is 1.
// - Overflow-clear branch jumps to PC+offset+1 when overflow is 0.
// - Interrupts-on branch jumps to PC+offset+1 when global interrupt enable is 1.
// - Interrupts-off branch jumps to PC+offset+1 when global interrupt enable is 0.
// - Copy writes source to destination, constant load writes the constant, no flag changes.
module cbm_exec
    import cbm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire cbm_instr_t instr,
    input wire cbm_flags_t flags,
    output logic instr_ready,
    output logic [PC_W-1:0] pc,
    output logic pc_load,
    output logic flush,
    output logic reg_we,
    output logic [REG_AW-1:0] reg_waddr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] copy_rdata
);

    // ************************************************************
    // Register file
    // ************************************************************
    logic [DATA_W-1:0] regs [NUM_REGS];
    logic [DATA_W-1:0] src_value;

    assign src_value = regs[instr.src];

    // ************************************************************
    // Branch decision
    // ************************************************************
    logic is_branch;
    logic cond;
    logic accept;
    logic [PC_W-1:0] ofs_ext;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] fall;

    // Condition per branch kind
    always_comb begin
        is_branch = 1'b1;
        cond = 1'b0;
        case (instr.op)
            CBM_OP_BRANCH_SIGNED_GE: cond = (flags.negative ^ flags.overflow) == 1'b0;
            CBM_OP_BRANCH_SIGNED_LT: cond = (flags.negative ^ flags.overflow) == 1'b1;
            CBM_OP_BRANCH_HALF_CARRY_SET: cond = flags.half_carry;
            CBM_OP_BRANCH_HALF_CARRY_CLEAR: cond = !flags.half_carry;
            CBM_OP_BRANCH_TRANSFER_BIT_SET: cond = flags.transfer;
            CBM_OP_BRANCH_TRANSFER_BIT_CLEAR: cond = !flags.transfer;
            CBM_OP_BRANCH_OVERFLOW_SET: cond = flags.overflow;
            CBM_OP_BRANCH_OVERFLOW_CLEAR: cond = !flags.overflow;
            CBM_OP_BRANCH_IRQ_ON: cond = flags.irq_enable;
            CBM_OP_BRANCH_IRQ_OFF: cond = !flags.irq_enable;
            default: is_branch = 1'b0;
        endcase
    end

    // Sign-extended displacement and targets
    assign ofs_ext = {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset};
    assign fall = pc + PC_STEP;
    assign target = pc + ofs_ext + PC_STEP;

    // ************************************************************
    // Sequencer and program counter
    // ************************************************************
    cbm_state_t state;
    cbm_state_t next_state;
    logic [PC_W-1:0] next_pc;
    logic next_pc_load;
    logic next_flush;
    logic next_ready;

    assign accept = instr_valid && instr_ready;

    // Next state and PC
    always_comb begin
        next_state = state;
        next_pc = pc;
        next_pc_load = 1'b0;
        next_flush = 1'b0;
        next_ready = 1'b1;
        case (state)
            CBM_ST_EXEC: begin
                if (accept) begin
                    if (is_branch && cond) begin
                        next_pc = target;
                        next_pc_load = 1'b1;
                        next_flush = 1'b1;
                        next_ready = 1'b0;
                        next_state = CBM_ST_FLUSH;
                    end else begin
                        next_pc = fall;
                    end
                end
            end
            CBM_ST_FLUSH: begin
                next_state = CBM_ST_EXEC;
            end
            default: begin
                next_state = CBM_ST_EXEC;
            end
        endcase
    end

    // Register sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= CBM_ST_EXEC;
            pc <= PC_RESET;
            pc_load <= 1'b0;
            flush <= 1'b0;
            instr_ready <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            pc_load <= next_pc_load;
            flush <= next_flush;
            instr_ready <= next_ready;
        end
    end

    // ************************************************************
    // Data transfer
    // ************************************************************
    logic next_we;
    logic [REG_AW-1:0] next_waddr;
    logic [DATA_W-1:0] next_wdata;

    // Write-back selection
    always_comb begin
        next_we = 1'b0;
        next_waddr = instr.dst;
        next_wdata = reg_wdata;
        if (accept && state == CBM_ST_EXEC) begin
            if (instr.op == CBM_OP_REGISTER_COPY) begin
                next_we = 1'b1;
                next_wdata = src_value;
            end else if (instr.op == CBM_OP_CONSTANT_LOAD) begin
                next_we = 1'b1;
                next_wdata = instr.imm;
            end
        end
    end

    // Register write-back strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_we <= 1'b0;
            reg_waddr <= '0;
            reg_wdata <= REG_RESET;
        end else begin
            reg_we <= next_we;
            reg_waddr <= next_waddr;
            reg_wdata <= next_wdata;
        end
    end

    // Register array update, on the same clock edge that accepts the instruction
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (next_we) begin
            regs[next_waddr] <= next_wdata;
        end
    end

    // Observed source value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            copy_rdata <= REG_RESET;
        end else begin
            copy_rdata <= src_value;
        end
    end

endmodule

// file: logic/cbm_pkg.sv
package cbm_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PC_W = 11;
    localparam int OFS_W = 7;
    localparam int REG_AW = 5;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 32;

    // ************************************************************
    // Reset values and program counter step
    // ************************************************************
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;

    // ************************************************************
    // Operation codes presented by the decoder
    // ************************************************************
    typedef enum logic [3:0] {
        CBM_OP_NONE = 4'h0,
        CBM_OP_BRANCH_SIGNED_GE = 4'h1,
        CBM_OP_BRANCH_SIGNED_LT = 4'h2,
        CBM_OP_BRANCH_HALF_CARRY_SET = 4'h3,
        CBM_OP_BRANCH_HALF_CARRY_CLEAR = 4'h4,
        CBM_OP_BRANCH_TRANSFER_BIT_SET = 4'h5,
        CBM_OP_BRANCH_TRANSFER_BIT_CLEAR = 4'h6,
        CBM_OP_BRANCH_OVERFLOW_SET = 4'h7,
        CBM_OP_BRANCH_OVERFLOW_CLEAR = 4'h8,
        CBM_OP_BRANCH_IRQ_ON = 4'h9,
        CBM_OP_BRANCH_IRQ_OFF = 4'hA,
        CBM_OP_REGISTER_COPY = 4'hB,
        CBM_OP_CONSTANT_LOAD = 4'hC
    } cbm_op_t;

    // Status flags read by the branches
    typedef struct packed {
        logic irq_enable;
        logic transfer;
        logic half_carry;
        logic overflow;
        logic negative;
    } cbm_flags_t;

    // One decoded instruction
    typedef struct packed {
        cbm_op_t op;
        logic [OFS_W-1:0] offset;
        logic [REG_AW-1:0] dst;
        logic [REG_AW-1:0] src;
        logic [DATA_W-1:0] imm;
    } cbm_instr_t;

    // Execution phase, Gray coded
    typedef enum logic [1:0] {
        CBM_ST_EXEC = 2'b00,
        CBM_ST_FLUSH = 2'b01
    } cbm_state_t;

endpackage

// file: verification/cbm_exec_chk.sv
`timescale 1ns/1ps
module cbm_exec_chk
    import cbm_pkg::*;
(
    input logic clk,
    input logic reset,
    input logic instr_valid,
    input cbm_instr_t instr,
    input logic instr_ready,
    input logic [PC_W-1:0] pc,
    input logic pc_load,
    input logic flush,
    input logic reg_we,
    input logic [REG_AW-1:0] reg_waddr,
    input logic [DATA_W-1:0] reg_wdata
);
    // ********
    // Execution checks
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Accept, branch and write qualifiers
    logic acc, br, wr;
    logic [PC_W-1:0] sx;
    assign acc = instr_valid && instr_ready;
    assign br = acc && instr.op inside {[CBM_OP_BRANCH_SIGNED_GE:CBM_OP_BRANCH_IRQ_OFF]};
    assign wr = acc && instr.op inside {CBM_OP_REGISTER_COPY, CBM_OP_CONSTANT_LOAD};
    assign sx = PC_W'($signed(instr.offset));
    // Pc, flush and write relations
    a_branch_target: assert property (br |=> pc == $past(pc) + PC_STEP +
        (pc_load ? $past(sx) : 11'h000)) else $error("bad target");
    a_plain_step: assert property (acc && !br |=>
        !pc_load && pc == $past(pc) + PC_STEP) else $error("bad step");
    a_flush_pair: assert property (pc_load == flush) else $error("flush split");
    a_flush_stall: assert property (pc_load |->
        !instr_ready ##1 instr_ready && !pc_load) else $error("bad stall");
    a_load_cause: assert property (pc_load |-> $past(br)) else $error("stray jump");
    a_write_cause: assert property (reg_we |-> $past(wr)) else $error("stray write");
    a_write_addr: assert property (wr |=> reg_we && reg_waddr == $past(instr.dst))
        else $error("bad address");
    a_load_data: assert property (acc && instr.op == CBM_OP_CONSTANT_LOAD |=>
        reg_wdata == $past(instr.imm)) else $error("bad constant");
endmodule

bind cbm_exec cbm_exec_chk i_chk (.clk, .reset, .instr_valid, .instr, .instr_ready, .pc,
    .pc_load, .flush, .reg_we, .reg_waddr, .reg_wdata);

// file: verification/cbm_exec_test.sv
`timescale 1ns/1ps
module cbm_exec_test;
    import cbm_pkg::*;
    logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, instr_ready, pc_load, flush, reg_we;
    cbm_instr_t instr = '0;
    cbm_flags_t flags = '0;
    logic [PC_W-1:0] pc, p0;
    logic [REG_AW-1:0] reg_waddr;
    logic [DATA_W-1:0] reg_wdata, copy_rdata;
    int err_count = 0, cmp_count = 0;
    // ********
    // Scenarios
    // ********
    cbm_exec i_dut (.clk, .reset, .instr_valid, .instr, .flags, .instr_ready, .pc,
        .pc_load, .flush, .reg_we, .reg_waddr, .reg_wdata, .copy_rdata);
    // Clock
    initial forever #5 clk = ~clk;
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One offer, held until taken
    task automatic send(cbm_op_t op, logic [6:0] o, logic [4:0] d, s, logic [7:0] i, cbm_flags_t f);
        @(posedge clk);
        instr <= '{op, o, d, s, i};
        flags <= f;
        instr_valid <= 1'b1;
        do @(negedge clk); while (instr_ready !== 1'b1);
        p0 = pc;
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
    endtask
    // Each branch with its condition false and true, one case at offset 3F and the other at offset 40
    task automatic branches();
        int bp [11] = '{0, 0, 0, 2, 2, 3, 3, 1, 1, 4, 4};
        logic [4:0] m;
        logic [6:0] ofs;
        logic [PC_W-1:0] exp;
        bit tk;
        for (int k = 1; k <= 10; k++) begin
            for (int v = 0; v < 2; v++) begin
                m = 5'h01 << bp[k];
                m = v ? m : ((k < 3) ? 5'h00 : ~m);
                tk = v[0] ^ k[0] ^ (k > 2);
                ofs = v ? 7'h40 : 7'h3F;
                send(cbm_op_t'(k), ofs, 5'h00, 5'h00, 8'h00, cbm_flags_t'(m));
                exp = p0 + PC_STEP + (tk ? PC_W'($signed(ofs)) : 11'h000);
                check("pc", 16'(exp), 16'(pc));
                check("jump", 16'(tk), 16'(pc_load));
                check("stall", {14'h0, tk, !tk}, {14'h0, flush, instr_ready});
            end
        end
    endtask
    // Constant load, then copy of it to the top register
    task automatic moves();
        send(CBM_OP_CONSTANT_LOAD, 7'h00, 5'h03, 5'h00, 8'hA5, '0);
        check("load", {3'h4, 5'h03, 8'hA5}, {reg_we, 2'h0, reg_waddr, reg_wdata});
        send(CBM_OP_REGISTER_COPY, 7'h00, 5'h1F, 5'h03, 8'h5A, '0);
        check("copy", {3'h4, 5'h1F, 8'hA5}, {reg_we, 2'h0, reg_waddr, reg_wdata});
        check("rdata", 16'(8'hA5), 16'(copy_rdata));
        check("step", {5'h00, p0 + PC_STEP}, {5'h00, pc});
    endtask
    // Reset, scenarios, verdict
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        branches();
        moves();
        conclude();
    end
    // Watchdog
    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule
